// ### hw/eeim_irq.v
// Energy metering event interrupt enable, status and pulse output logic
//
// What this block does
// - Enable bit 0: interrupt when bit 30 of any total active energy changes.
// - Enable bit 1: interrupt when bit 30 of any fundamental active energy changes.
// - Enable bit 2: interrupt when bit 30 of any total reactive energy changes.
// - Enable bit 3: interrupt when bit 30 of any fundamental reactive energy changes.
// - Enable bit 4: interrupt when bit 30 of any apparent energy changes.
// - Enable bit 5: interrupt at end of line cycle accumulation, in that mode only.
// - Bits 6-8 enable phase A-C active sign change; mode bit 6 picks source.
// - Bits 10-12 enable phase A-C reactive sign change; mode bit 7 picks source.
// - Bits 9, 13, 18 enable sign change of pulse datapath sums 1-3.
// - Bits 14-16 enable interrupt on falling edge of pulse outputs 1-3.
// - Pulse interrupts still occur while the pulse pin is disabled.
// - Three-bit fields [2:0], [5:3], [8:6] choose power type per pulse output.
// - Enable bit 17: interrupt when each 8 kHz processing cycle finishes.
// - Enable bits 31 to 19 are reserved, do nothing, read zero.
// - Reset completion raises the second interrupt pin low, never maskable.
//
// The Avalon-MM interface to the registers was left to the implementer.
`include "eeim_defines.vh"

module eeim_irq #(
    parameter ADDR_W  = 18,                 // Byte address width
    parameter PTYPE_N = 8                   // Number of selectable pulse power types
) (
    input  wire                clock,        // 100 MHz clock
    input  wire                rst_n,        // Synchronous reset, active low
    input  wire [ADDR_W-1:0]   address,      // Avalon byte address
    input  wire                read,         // Avalon read request
    input  wire                write,        // Avalon write request
    input  wire [3:0]          byteenable,   // Avalon byte lanes
    input  wire [31:0]         writedata,    // Avalon write data
    output reg  [31:0]         readdata,     // Avalon read data, registered
    output wire                waitrequest,  // Avalon wait request
    input  wire [2:0]          tot_act_b30,  // Bit 30 of total active energy, phases A-C
    input  wire [2:0]          fund_act_b30, // Bit 30 of fundamental active energy
    input  wire [2:0]          tot_react_b30, // Bit 30 of total reactive energy
    input  wire [2:0]          fund_react_b30, // Bit 30 of fundamental reactive energy
    input  wire [2:0]          apparent_b30, // Bit 30 of apparent energy
    input  wire                line_cycle_mode, // Line cycle accumulation mode active
    input  wire                line_cycle_done, // One-cycle pulse: half cycle count reached
    input  wire [2:0]          tot_act_sign, // Sign of total active power A-C
    input  wire [2:0]          fund_act_sign, // Sign of fundamental active power A-C
    input  wire [2:0]          tot_react_sign, // Sign of total reactive power A-C
    input  wire [2:0]          fund_react_sign, // Sign of fundamental reactive power A-C
    input  wire [2:0]          pulse_sum_sign, // Sign of summed power in pulse datapaths 1-3
    input  wire [PTYPE_N-1:0]  pulse_train_n, // Active-low pulse train for each power type
    input  wire                dsp_cycle_done, // One-cycle pulse: 8 kHz computations finished
    input  wire                power_mode_done, // One-cycle pulse: power mode transition ended
    output reg  [2:0]          pulse_out_n,  // Pulse output pins 1-3, active low
    output wire                irq_n,        // Event interrupt, active low
    output wire                second_irq_pin_n // Reset completion interrupt, active low
);

    // ****************************************************************
    // Local helpers
    // ****************************************************************

    // Merge a write through byte enables
    function [31:0] merge_be;
        input [31:0] old_v;
        input [31:0] new_v;
        input [3:0]  be;
        integer      i;
        begin
            merge_be = old_v;
            for (i = 0; i < 4; i = i + 1) begin
                if (be[i]) begin
                    merge_be[i*8 +: 8] = new_v[i*8 +: 8];
                end
            end
        end
    endfunction

    // Match a byte address against a register index
    function hit;
        input [ADDR_W-1:0] addr;
        input [15:0]       idx;
        begin
            hit = (addr == {idx[ADDR_W-3:0], 2'b00});
        end
    endfunction

    // ****************************************************************
    // Bus slave
    // ****************************************************************

    reg  [31:0] enable_reg;
    reg  [31:0] status_reg;
    reg  [31:0] status_next;
    reg  [31:0] accumulation_mode_reg_reg;
    reg  [31:0] pulsemode_reg;
    reg         ack_reg;
    reg  [31:0] rd_next;

    wire        req       = read | write;
    wire        wr_strobe = write & ack_reg;

    // One wait cycle per access: read data is loaded in it and stands at the release edge
    assign waitrequest = req & ~ack_reg;

    always @(posedge clock) begin
        if (!rst_n) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= req & ~ack_reg;
        end
    end

    // Read decode; unmapped addresses read zero
    always @* begin
        rd_next = 32'h00000000;
        if (hit(address, `EEIM_IDX_ENABLE)) begin
            rd_next = enable_reg & `EEIM_ENABLE_MASK;
        end else if (hit(address, `EEIM_IDX_STATUS)) begin
            rd_next = status_reg;
        end else if (hit(address, `EEIM_IDX_ACCUMULATION_MODE_REG)) begin
            rd_next = accumulation_mode_reg_reg;
        end else if (hit(address, `EEIM_IDX_PULSEMODE)) begin
            rd_next = pulsemode_reg;
        end
    end

    always @(posedge clock) begin
        if (!rst_n) begin
            readdata <= 32'h00000000;
        end else if (read & ~ack_reg) begin
            readdata <= rd_next;
        end
    end

    // Writable registers; reserved bits never store
    always @(posedge clock) begin
        if (!rst_n) begin
            enable_reg    <= `EEIM_ENABLE_RESET;
            accumulation_mode_reg_reg   <= `EEIM_ACCUMULATION_MODE_REG_RESET;
            pulsemode_reg <= `EEIM_PULSEMODE_RESET;
        end else if (wr_strobe) begin
            if (hit(address, `EEIM_IDX_ENABLE)) begin
                enable_reg <= merge_be(enable_reg, writedata, byteenable) & `EEIM_ENABLE_MASK;
            end else if (hit(address, `EEIM_IDX_ACCUMULATION_MODE_REG)) begin
                accumulation_mode_reg_reg <= merge_be(accumulation_mode_reg_reg, writedata, byteenable) & `EEIM_ACCUMULATION_MODE_REG_MASK;
            end else if (hit(address, `EEIM_IDX_PULSEMODE)) begin
                pulsemode_reg <= merge_be(pulsemode_reg, writedata, byteenable) & `EEIM_PULSEMODE_MASK;
            end
        end
    end

    // ****************************************************************
    // Event detection
    // ****************************************************************

    // Sign sources picked by the accumulation mode selects
    wire [2:0] act_sign   = accumulation_mode_reg_reg[`EEIM_ACC_ACT_SEL] ? fund_act_sign : tot_act_sign;
    wire [2:0] react_sign = accumulation_mode_reg_reg[`EEIM_ACC_REACT_SEL] ? fund_react_sign : tot_react_sign;

    // Internal pulse trains per output, chosen before the pin disable
    wire [2:0] psel1 = pulsemode_reg[`EEIM_PM_SEL1_LSB +: 3];
    wire [2:0] psel2 = pulsemode_reg[`EEIM_PM_SEL2_LSB +: 3];
    wire [2:0] psel3 = pulsemode_reg[`EEIM_PM_SEL3_LSB +: 3];
    wire [2:0] pulse_int_n = {pulse_train_n[psel3], pulse_train_n[psel2], pulse_train_n[psel1]};

    // Sampled copies for change and edge detection
    reg  [14:0] b30_prev_reg;
    reg  [2:0]  act_prev_reg;
    reg  [2:0]  react_prev_reg;
    reg  [2:0]  psum_prev_reg;
    reg  [2:0]  pulse_prev_reg;
    reg         primed_reg;

    wire [14:0] b30_now = {apparent_b30, fund_react_b30, tot_react_b30, fund_act_b30, tot_act_b30};
    wire [14:0] b30_chg = (b30_now ^ b30_prev_reg) & {15{primed_reg}};

    // A select change can flip the sign source; that is reported as a sign change
    always @(posedge clock) begin
        if (!rst_n) begin
            b30_prev_reg   <= 15'h0000;
            act_prev_reg   <= 3'h0;
            react_prev_reg <= 3'h0;
            psum_prev_reg  <= 3'h0;
            pulse_prev_reg <= 3'h7;
            primed_reg     <= 1'b0;
        end else begin
            b30_prev_reg   <= b30_now;
            act_prev_reg   <= act_sign;
            react_prev_reg <= react_sign;
            psum_prev_reg  <= pulse_sum_sign;
            pulse_prev_reg <= pulse_int_n;
            primed_reg     <= 1'b1;
        end
    end

    // Pulse pins driven from flip-flops; disable forces them idle high
    always @(posedge clock) begin
        if (!rst_n) begin
            pulse_out_n <= 3'h7;
        end else begin
            pulse_out_n <= pulse_int_n | pulsemode_reg[`EEIM_PM_DIS1 +: 3];
        end
    end

    reg [31:0] events;

    // Gather one-cycle events in status layout
    always @* begin
        events = 32'h00000000;
        events[`EEIM_B_TOT_ACT]    = |b30_chg[2:0];
        events[`EEIM_B_FUND_ACT]   = |b30_chg[5:3];
        events[`EEIM_B_TOT_REACT]  = |b30_chg[8:6];
        events[`EEIM_B_FUND_REACT] = |b30_chg[11:9];
        events[`EEIM_B_APPARENT]   = |b30_chg[14:12];
        events[`EEIM_B_LINE_DONE]  = line_cycle_mode & line_cycle_done;
        events[`EEIM_B_ACT_SIGN_A +: 3]   = (act_sign ^ act_prev_reg) & {3{primed_reg}};
        events[`EEIM_B_REACT_SIGN_A +: 3] = (react_sign ^ react_prev_reg) & {3{primed_reg}};
        events[`EEIM_B_PSUM1] = primed_reg & (pulse_sum_sign[0] ^ psum_prev_reg[0]);
        events[`EEIM_B_PSUM2] = primed_reg & (pulse_sum_sign[1] ^ psum_prev_reg[1]);
        events[`EEIM_B_PSUM3] = primed_reg & (pulse_sum_sign[2] ^ psum_prev_reg[2]);
        // Taken from the internal train so a disabled pin still interrupts
        events[`EEIM_B_PULSE1 +: 3] = pulse_prev_reg & ~pulse_int_n;
        events[`EEIM_B_DSP_DONE]  = dsp_cycle_done;
        events[`EEIM_B_RST_DONE]  = power_mode_done;
    end

    // ****************************************************************
    // Status and interrupt outputs
    // ****************************************************************

    // Write one to clear; a new event in the same cycle wins over the clear
    always @* begin
        status_next = status_reg;
        if (wr_strobe && hit(address, `EEIM_IDX_STATUS)) begin
            status_next = status_reg & ~merge_be(32'h00000000, writedata, byteenable);
        end
        status_next = status_next | events;
    end

    // Reset completion is loaded by reset with all defaults, so it is already set while reset is held
    always @(posedge clock) begin
        if (!rst_n) begin
            status_reg <= `EEIM_STATUS_RESET;
        end else begin
            status_reg <= status_next;
        end
    end

    // Reset completion lies outside the enable field, so it can never be masked
    wire [31:0] gated = status_reg & enable_reg & `EEIM_ENABLE_MASK & ~(32'h1 << `EEIM_B_RST_DONE);

    assign irq_n            = ~(|gated);
    assign second_irq_pin_n = ~status_reg[`EEIM_B_RST_DONE];

endmodule

// ### inc/eeim_defines.vh
// Register map, field positions and reset values of the energy event interrupt block
`ifndef EEIM_DEFINES_VH
`define EEIM_DEFINES_VH

// Register indices; the byte address is four times the index
`define EEIM_IDX_ENABLE      16'hE50A
`define EEIM_IDX_STATUS      16'hE520
`define EEIM_IDX_ACCUMULATION_MODE_REG     16'hE530
`define EEIM_IDX_PULSEMODE   16'hE531

// Event bit positions, shared by enable and status
`define EEIM_B_TOT_ACT       0
`define EEIM_B_FUND_ACT      1
`define EEIM_B_TOT_REACT     2
`define EEIM_B_FUND_REACT    3
`define EEIM_B_APPARENT      4
`define EEIM_B_LINE_DONE     5
`define EEIM_B_ACT_SIGN_A    6
`define EEIM_B_PSUM1         9
`define EEIM_B_REACT_SIGN_A  10
`define EEIM_B_PSUM2         13
`define EEIM_B_PULSE1        14
`define EEIM_B_DSP_DONE      17
`define EEIM_B_PSUM3         18
// Reset completion sits above the event field, so no enable bit can reach it
`define EEIM_B_RST_DONE      19
`define EEIM_EVENT_W         19

// Implemented bits of enable, [31:19] reserved
`define EEIM_ENABLE_MASK     32'h0007FFFF
`define EEIM_ENABLE_RESET    32'h00000000
`define EEIM_STATUS_RESET    32'h00080000

// Accumulation mode fields
`define EEIM_ACC_ACT_SEL     6
`define EEIM_ACC_REACT_SEL   7
`define EEIM_ACCUMULATION_MODE_REG_MASK    32'h000000C0
`define EEIM_ACCUMULATION_MODE_REG_RESET   32'h00000000

// Pulse mode fields
`define EEIM_PM_SEL1_LSB     0
`define EEIM_PM_SEL2_LSB     3
`define EEIM_PM_SEL3_LSB     6
`define EEIM_PM_DIS1         9
`define EEIM_PULSEMODE_MASK  32'h00000FFF
`define EEIM_PULSEMODE_RESET 32'h00000000

`endif

// ### bench/eeim_irq_checker.sv
// Port-level assertions for the energy event interrupt block
module eeim_irq_checker #(
    parameter ADDR_W  = 18, // Byte address width
    parameter PTYPE_N = 8   // Pulse power types
) (
    input wire logic               clock,           // Clock
    input wire logic               rst_n,           // Reset, active low
    input wire logic               read,            // Bus read
    input wire logic               write,           // Bus write
    input wire logic [ADDR_W-1:0]  address,         // Bus address
    input wire logic [31:0]        readdata,        // Read data
    input wire logic               waitrequest,     // Bus stall
    input wire logic               power_mode_done, // Mode change done
    input wire logic [PTYPE_N-1:0] pulse_train_n,   // Pulse trains
    input wire logic [2:0]         pulse_out_n,     // Pulse pins
    input wire logic               irq_n,           // Event interrupt
    input wire logic               second_irq_pin_n // Reset-done interrupt
);
    // ****************
    // Properties
    // ****************
    // One domain, so one clock and one disable serve all
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    property p_rst_irq; $rose(rst_n) |-> irq_n; endproperty
    a_rst_irq: assert property (p_rst_irq) else $error("irq low after reset");
    // Status is sticky and enable only moves by a write
    property p_irq_hold; !irq_n && !write |=> !irq_n; endproperty
    a_irq_hold: assert property (p_irq_hold) else $error("irq released without a write");
    property p_rst_done; $rose(rst_n) |-> !second_irq_pin_n; endproperty
    a_rst_done: assert property (p_rst_done) else $error("no reset-done interrupt");
    property p_pwr_done; power_mode_done |=> !second_irq_pin_n; endproperty
    a_pwr_done: assert property (p_pwr_done) else $error("mode change not signalled");
    property p_sec_hold; !second_irq_pin_n && !write |=> !second_irq_pin_n; endproperty
    a_sec_hold: assert property (p_sec_hold) else $error("reset-done released alone");
    property p_sec_fall; $fell(second_irq_pin_n) |-> $past(power_mode_done); endproperty
    a_sec_fall: assert property (p_sec_fall) else $error("reset-done without cause");
    // No train low means no pin can pulse, whatever the selects
    property p_pulse_idle; $past(&pulse_train_n) |-> &pulse_out_n; endproperty
    a_pulse_idle: assert property (p_pulse_idle) else $error("pulse without train");
    property p_rsv; read && !waitrequest && address == 18'h39428 |-> readdata[31:19] == 13'h0; endproperty
    a_rsv: assert property (p_rsv) else $error("reserved enable bits nonzero");
endmodule

bind eeim_irq eeim_irq_checker #(.ADDR_W(ADDR_W), .PTYPE_N(PTYPE_N)) u_chk (.clock(clock), .rst_n(rst_n),
    .read(read), .write(write), .address(address), .readdata(readdata), .waitrequest(waitrequest),
    .power_mode_done(power_mode_done), .pulse_train_n(pulse_train_n), .pulse_out_n(pulse_out_n),
    .irq_n(irq_n), .second_irq_pin_n(second_irq_pin_n));

// ### bench/eeim_host.sv
// Host model: bus master that reaches the event registers
module eeim_host (
    input  wire logic        clock,       // Clock
    input  wire logic        waitrequest, // Slave stall
    input  wire logic [31:0] readdata,    // Read data
    output logic      [17:0] address,     // Byte address
    output logic             read,        // Read request
    output logic             write,       // Write request
    output logic      [3:0]  byteenable,  // Byte lanes
    output logic      [31:0] writedata,   // Write data
    output logic             stuck        // Wait ran out
);
    timeunit 1ns;
    timeprecision 1ps;
    // Idle bus at time zero
    initial begin
        address = 18'h0;
        read = 1'b0;
        write = 1'b0;
        byteenable = 4'hF;
        writedata = 32'h0;
        stuck = 1'b0;
    end
    // One transfer, held until waitrequest is seen low at an edge
    task automatic xfer(input logic wr, input logic [17:0] a, input logic [31:0] d, output logic [31:0] q);
        int n;
        @(posedge clock);
        address <= a;
        writedata <= d;
        read <= ~wr;
        write <= wr;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (waitrequest !== 1'b0 && n < 50);
        q = readdata;
        if (waitrequest !== 1'b0) stuck <= 1'b1;
        read <= 1'b0;
        write <= 1'b0;
        writedata <= ~d; // Released data must not look still valid
    endtask
endmodule

// ### bench/eeim_irq_tb_top.sv
// Testbench for the energy event interrupt block
module eeim_irq_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [17:0] A_EN = 18'h39428;
    localparam logic [17:0] A_ST = 18'h39480;
    localparam logic [17:0] A_PM = 18'h394C4;
    localparam logic [17:0] A_AM = 18'h394C0;
    logic        clock, rst_n, lmode, ldone, dsp, pmd, rd, wr_s, wait_s, irq_n, sec_n, stuck;
    logic [14:0] b30;
    logic [11:0] sg;
    logic [2:0]  psum, pout;
    logic [7:0]  train;
    logic [17:0] addr;
    logic [3:0]  be;
    logic [31:0] wdata, rdata;
    int          failures, cmp_count, cyc;
    // ****************
    // Design, host and clock
    // ****************
    eeim_irq dut (.clock(clock), .rst_n(rst_n), .address(addr), .read(rd), .write(wr_s), .byteenable(be),
        .writedata(wdata), .readdata(rdata), .waitrequest(wait_s), .tot_act_b30(b30[2:0]),
        .fund_act_b30(b30[5:3]), .tot_react_b30(b30[8:6]), .fund_react_b30(b30[11:9]),
        .apparent_b30(b30[14:12]), .line_cycle_mode(lmode), .line_cycle_done(ldone), .tot_act_sign(sg[2:0]),
        .fund_act_sign(sg[5:3]), .tot_react_sign(sg[8:6]), .fund_react_sign(sg[11:9]), .pulse_sum_sign(psum),
        .pulse_train_n(train), .dsp_cycle_done(dsp), .power_mode_done(pmd), .pulse_out_n(pout),
        .irq_n(irq_n), .second_irq_pin_n(sec_n));
    eeim_host host (.clock(clock), .waitrequest(wait_s), .readdata(rdata), .address(addr), .read(rd),
        .write(wr_s), .byteenable(be), .writedata(wdata), .stuck(stuck));
    always #5 clock = ~clock;
    task automatic report_and_stop();
        if (failures == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // A hung bus or an overlong run ends the test as failed
    always @(posedge clock) begin
        cyc++;
        if (stuck === 1'b1 || cyc > 50000) begin
            failures++;
            report_and_stop();
        end
    end
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wr(input logic [17:0] a, input logic [31:0] d);
        logic [31:0] q;
        host.xfer(1'b1, a, d, q);
    endtask
    task automatic rd_chk(input string nm, input logic [17:0] a, input logic [31:0] exp);
        logic [31:0] q;
        host.xfer(1'b0, a, 32'h0, q);
        chk(nm, exp, q);
    endtask
    // Raise event i for one cycle; each sign toggle is one change
    task automatic fire(input int i);
        @(posedge clock);
        case (i)
            0, 1, 2, 3, 4: b30[i*3+i%3] <= ~b30[i*3+i%3];
            5: ldone <= 1'b1;
            6, 7, 8: sg <= sg ^ (12'h009 << (i - 6));
            10, 11, 12: sg <= sg ^ (12'h240 << (i - 10));
            9, 13, 18: psum <= psum ^ ((i == 9) ? 3'h1 : (i == 13) ? 3'h2 : 3'h4);
            14, 15, 16: train[i-13] <= 1'b0;
            default: dsp <= 1'b1;
        endcase
        @(posedge clock);
        ldone <= 1'b0;
        dsp <= 1'b0;
        train <= 8'hFF;
    endtask
    // ****************
    // Scenarios
    // ****************
    task automatic t_reset_done();
        chk("irq_n", 1, irq_n);
        chk("second_irq_pin_n", 0, sec_n);
        rd_chk("enable", A_EN, 32'h0);
        rd_chk("status", A_ST, 32'h00080000);
        rd_chk("pulse mode", A_PM, 32'h0);
        wr(A_EN, 32'h0007FFFF);
        wr(A_ST, 32'h00080000);
        @(posedge clock);
        chk("second_irq_pin_n", 1, sec_n);
        pmd <= 1'b1;
        @(posedge clock);
        pmd <= 1'b0;
        @(posedge clock);
        chk("second_irq_pin_n", 0, sec_n);
        chk("irq_n", 1, irq_n);
        wr(A_ST, 32'h00080000);
        wr(A_EN, 32'h0);
    endtask
    task automatic t_reserved();
        wr(A_EN, 32'hFFFFFFFF);
        rd_chk("enable", A_EN, 32'h0007FFFF);
        wr(A_EN, 32'h0);
        wr(18'h39400, 32'hFFFFFFFF);
        rd_chk("unmapped", 18'h39400, 32'h0);
    endtask
    // Pulse pins pick trains 1..3 and are disabled meanwhile
    task automatic t_events();
        wr(A_PM, 32'h00000ED1);
        fire(5);
        rd_chk("status", A_ST, 32'h0);
        lmode <= 1'b1;
        for (int i = 0; i < 19; i++) begin
            fire(i);
            rd_chk("status", A_ST, 32'h1 << i);
            chk("irq_n", 1, irq_n);
            chk("pulse_out_n", 7, pout);
            wr(A_EN, 32'h1 << i);
            @(posedge clock);
            chk("irq_n", 0, irq_n);
            wr(A_ST, 32'h1 << i);
            @(posedge clock);
            chk("irq_n", 1, irq_n);
            wr(A_EN, 32'h0);
        end
    endtask
    // Select fundamental signs: total toggles are ignored, fundamental ones count
    task automatic t_sign_sel();
        wr(A_AM, 32'h000000C0);
        @(posedge clock);
        sg <= sg ^ 12'h041;
        repeat (2) @(posedge clock);
        rd_chk("status", A_ST, 32'h0);
        sg <= sg ^ 12'h208;
        repeat (2) @(posedge clock);
        rd_chk("status", A_ST, 32'h00000440);
        wr(A_ST, 32'h00000440);
        wr(A_AM, 32'h0);
        rd_chk("status", A_ST, 32'h0);
    endtask
    // All three pins follow one train, then pin 1 is disabled
    task automatic t_pulse();
        wr(A_PM, 32'h00000092);
        @(posedge clock);
        train[2] <= 1'b0;
        repeat (2) @(posedge clock);
        chk("pulse_out_n", 3'b000, pout);
        wr(A_PM, 32'h00000292);
        repeat (2) @(posedge clock);
        chk("pulse_out_n", 3'b001, pout);
        train[2] <= 1'b1;
    endtask
    // Main sequence
    initial begin
        clock = 1'b0;
        rst_n = 1'b0;
        {b30, sg, psum, lmode, ldone, dsp, pmd} = '0;
        train = 8'hFF;
        repeat (16) @(posedge clock);
        rst_n <= 1'b1;
        repeat (2) @(posedge clock);
        t_reset_done();
        t_reserved();
        t_events();
        t_sign_sel();
        t_pulse();
        report_and_stop();
    end
endmodule
